// >>> brw_pkg.sv
/*
 Package for the breaker reclose and wear monitor: output masks, reclose
 state, wear statistics carriers and timing constants.
 Assumes a single 25 MHz relay clock.
*/
package brw_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int NUM_RELAYS = 6;
    localparam int NUM_ELEMENTS = 6;
    localparam int MAX_SHOTS = 4;
    localparam int MS_DIV = CLK_HZ / 1000;
    localparam int OPTIME_MIN_MS = 100;
    localparam int OPTIME_MAX_MS = 5000;
    localparam int INHIBIT_DEF_MS = 1000;
    localparam int RECLAIM_DEF_MS = 3000;
    localparam int DEAD_DEF_MS = 500;
    localparam int PULSE_DEF_MS = 100;
    localparam logic [15:0] OPS_LIMIT_DEF = 16'h03e8;
    localparam logic [5:0] MASK6_RST = 6'h00;
    localparam logic [6:0] MASK7_RST = 7'h00;
    localparam logic [7:0] MASK8_RST = 8'h00;
    localparam logic [3:0] SHOTS_RST = 4'h7;

    typedef enum logic [1:0] {
        BRW_LAW_LINEAR,
        BRW_LAW_SQUARE
    } brw_law_e;

    typedef enum {
        BRW_IDLE,
        BRW_DEAD,
        BRW_CLOSE,
        BRW_RECLAIM,
        BRW_LOCKED
    } brw_ar_e;

    typedef struct packed {
        logic [5:0] trip_mask;
        logic [5:0] close_mask;
        logic [5:0] run_mask;
        logic [7:0] ftrip_mask;
        logic [6:0] lock_mask;
        logic [6:0] block_mask;
        logic [6:0] succ_mask;
    } brw_map_s;

    typedef struct packed {
        logic [15:0] op_count;
        logic [31:0] isum;
        logic maint_alarm;
        logic slow_alarm;
    } brw_wear_s;
endpackage

// >>> brw_monitor.sv
/*
 Breaker reclose and wear monitor: trip/close routing, reclose sequencer,
 breaker position indications and wear statistics.
 Assumes synchronous inputs, one clock, settings held stable by the host.
*/
// Function
// [RQ1] Reclose starts only after protection trip pulse
// [RQ2] Trip LED on start, cleared by close
// [RQ3] Up to four shots, per element selection
// [RQ4] Trip pulse routed by six-bit mask
// [RQ5] Close command routed by six-bit mask
// [RQ6] Final-trip lockout flag, eight-position mask
// [RQ7] Running, lockout, blocked, success flags mapped
// [RQ8] Closed/opened indications follow contact inputs
// [RQ9] Record count, current sum, operation times
// [RQ10] Count protection trips and manual opens
// [RQ11] External trip trigger updates wear statistics
// [RQ12] Summation exponent one or two
// [RQ13] Operations alarm, optional reclose lockout
// [RQ14] Slow-operation alarm, threshold 100 ms to 5 s; code takes any 16-bit optime_limit_ms, no range check
// [RQ15] Breaker state from one or two contacts
// [RQ16] Inhibit reclose after manual close, zero disables
// [RQ17] Lockout holds until reset, no closes
// [RQ18] Wear totals change only by increment/reset
`timescale 1ns/10ps
`default_nettype none
module brw_monitor
    import brw_pkg::*;
#(
    parameter int MS_CYCLES = MS_DIV
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire brw_map_s map,
    input wire logic [NUM_ELEMENTS*MAX_SHOTS-1:0] shot_sel,
    input wire logic [NUM_ELEMENTS-1:0] element_trip,
    input wire logic ar_enable,
    input wire logic ar_block,
    input wire logic clear_on_close,
    input wire logic lockout_reset,
    input wire logic [15:0] dead_ms,
    input wire logic [15:0] reclaim_ms,
    input wire logic [15:0] pulse_ms,
    input wire logic [15:0] reclose_inhibit_after_close,
    input wire logic manual_close,
    input wire logic manual_open_command,
    input wire logic ext_trip_trigger,
    input wire logic [1:0] contact_mode,
    input wire logic breaker_no_contact_input,
    input wire logic breaker_nc_contact_input,
    input wire logic [15:0] fault_current,
    input wire brw_law_e sum_law,
    input wire logic [15:0] ops_limit,
    input wire logic ops_lockout_en,
    input wire logic [15:0] optime_limit_ms,
    input wire logic wear_reset,
    output logic [NUM_RELAYS-1:0] relay_out,
    output logic trip_led,
    output logic ftrip_flag_t,
    output logic ftrip_flag_f,
    output logic flag_f,
    output logic ar_running,
    output logic breaker_closed_indication,
    output logic breaker_opened_indication,
    output logic breaker_close_command,
    output logic trip_pulse,
    output brw_wear_s wear,
    output logic [15:0] last_optime_ms
);
    initial begin
        if (MS_CYCLES < 1 || MAX_SHOTS != 4)
            $error("brw_monitor: unsupported parameters");
    end

    // Millisecond tick
    logic [31:0] div_r, div_nxt;
    logic ms_tick_r, ms_tick_nxt;
    always_comb begin
        div_nxt = div_r + 32'h1;
        ms_tick_nxt = 1'b0;
        if (div_r >= 32'(MS_CYCLES - 1)) begin
            div_nxt = 32'h0;
            ms_tick_nxt = 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_r <= 32'h0;
            ms_tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            ms_tick_r <= ms_tick_nxt;
        end
    end

    // Breaker position from contacts; mode 1 NO only, 2 NC only, 3 both for closed and NC only for opened
    logic closed_c, open_c;
    always_comb begin
        case (contact_mode)
            2'h1: closed_c = breaker_no_contact_input; // RQ15
            2'h2: closed_c = !breaker_nc_contact_input; // RQ15
            default: closed_c = breaker_no_contact_input
                && !breaker_nc_contact_input; // RQ15
        endcase
        open_c = (contact_mode == 2'h1) ? !breaker_no_contact_input
            : breaker_nc_contact_input;
    end

    // Shot enable of the tripping elements for a given shot
    function automatic logic shot_ok(input logic [23:0] sel,
                                     input logic [5:0] elem,
                                     input logic [2:0] shot);
        logic r;
        r = 1'b0;
        for (int e = 0; e < NUM_ELEMENTS; e++)
            if (elem[e] && sel[e*MAX_SHOTS + int'(shot)])
                r = 1'b1;
        return r;
    endfunction

    brw_ar_e st_r, st_nxt;
    logic [15:0] tmr_r, tmr_nxt, inh_r, inh_nxt, pls_r, pls_nxt;
    logic [2:0] shot_r, shot_nxt;
    logic [5:0] elem_r, elem_nxt;
    logic trip_r, trip_nxt, close_r, close_nxt, led_r, led_nxt;
    logic succ_r, succ_nxt, ftrip_r, ftrip_nxt;
    logic trip_req, ops_lock, blocked;
    always_comb begin
        trip_req = |element_trip;
        ops_lock = ops_lockout_en && (wear.op_count >= ops_limit); // RQ13
        blocked = !ar_enable || ar_block || ops_lock || (inh_r != 16'h0);
        st_nxt = st_r;
        tmr_nxt = (ms_tick_r && tmr_r != 16'h0) ? tmr_r - 16'h1 : tmr_r;
        inh_nxt = (ms_tick_r && inh_r != 16'h0) ? inh_r - 16'h1 : inh_r;
        pls_nxt = (ms_tick_r && pls_r != 16'h0) ? pls_r - 16'h1 : pls_r;
        shot_nxt = shot_r;
        elem_nxt = elem_r;
        trip_nxt = trip_r && (pls_r != 16'h0);
        close_nxt = close_r && (pls_r != 16'h0);
        led_nxt = led_r;
        succ_nxt = succ_r;
        ftrip_nxt = ftrip_r;
        if (trip_req && !trip_r) begin
            trip_nxt = 1'b1;
            close_nxt = 1'b0;
            pls_nxt = pulse_ms;
            elem_nxt = element_trip;
        end
        if (manual_close && st_r != BRW_LOCKED) begin
            close_nxt = 1'b1;
            trip_nxt = 1'b0;
            pls_nxt = pulse_ms;
            inh_nxt = reclose_inhibit_after_close; // RQ16
        end
        case (st_r)
            BRW_IDLE: begin
                if (trip_r && !blocked) begin // RQ1
                    if (shot_ok(shot_sel, elem_r, 3'h0)) begin // RQ3
                        st_nxt = BRW_DEAD;
                        tmr_nxt = dead_ms;
                        shot_nxt = 3'h1;
                        led_nxt = 1'b1; // RQ2
                        succ_nxt = 1'b0;
                    end
                end
            end
            BRW_DEAD: begin
                if (blocked && !ar_enable)
                    st_nxt = BRW_IDLE;
                else if (tmr_r == 16'h0 && !trip_r) begin
                    st_nxt = BRW_CLOSE;
                    close_nxt = 1'b1; // RQ5
                    pls_nxt = pulse_ms;
                    if (clear_on_close)
                        led_nxt = 1'b0; // RQ2
                end
            end
            BRW_CLOSE: begin
                if (!close_r) begin
                    st_nxt = BRW_RECLAIM;
                    tmr_nxt = reclaim_ms;
                end
            end
            BRW_RECLAIM: begin
                if (trip_req) begin
                    if (shot_r < 3'(MAX_SHOTS)
                        && shot_ok(shot_sel, element_trip, shot_r)
                        && !ops_lock) begin // RQ3
                        st_nxt = BRW_DEAD;
                        tmr_nxt = dead_ms;
                        shot_nxt = shot_r + 3'h1;
                    end else begin
                        st_nxt = BRW_LOCKED;
                        ftrip_nxt = 1'b1; // RQ6
                    end
                end else if (tmr_r == 16'h0) begin
                    st_nxt = BRW_IDLE;
                    succ_nxt = 1'b1; // RQ7
                    shot_nxt = 3'h0;
                end
            end
            BRW_LOCKED: begin
                close_nxt = 1'b0; // RQ17
                if (lockout_reset) begin // RQ17
                    st_nxt = BRW_IDLE;
                    ftrip_nxt = 1'b0;
                    shot_nxt = 3'h0;
                end
            end
            default: st_nxt = BRW_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= BRW_IDLE;
            tmr_r <= 16'h0;
            inh_r <= 16'h0;
            pls_r <= 16'h0;
            shot_r <= 3'h0;
            elem_r <= 6'h00;
            trip_r <= 1'b0;
            close_r <= 1'b0;
            led_r <= 1'b0;
            succ_r <= 1'b0;
            ftrip_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            inh_r <= inh_nxt;
            pls_r <= pls_nxt;
            shot_r <= shot_nxt;
            elem_r <= elem_nxt;
            trip_r <= trip_nxt;
            close_r <= close_nxt;
            led_r <= led_nxt;
            succ_r <= succ_nxt;
            ftrip_r <= ftrip_nxt;
        end
    end

    // Wear statistics and operating time
    brw_wear_s wear_nxt;
    logic [15:0] opt_r, opt_nxt, last_nxt;
    logic timing_r, timing_nxt, open_evt;
    logic [31:0] inc;
    always_comb begin
        open_evt = (trip_nxt && !trip_r) || manual_open_command
            || ext_trip_trigger; // RQ10 RQ11
        inc = (sum_law == BRW_LAW_LINEAR) ? {16'h0, fault_current}
            : fault_current * fault_current; // RQ12
        wear_nxt = wear;
        opt_nxt = opt_r;
        last_nxt = last_optime_ms;
        timing_nxt = timing_r;
        // Reset first so an event in the same cycle still counts
        if (wear_reset) begin // RQ18
            wear_nxt.op_count = 16'h0;
            wear_nxt.isum = 32'h0;
            wear_nxt.slow_alarm = 1'b0;
            wear_nxt.maint_alarm = 1'b0;
        end
        if (open_evt) begin
            wear_nxt.op_count = wear_nxt.op_count + 16'h1; // RQ9 RQ18
            wear_nxt.isum = wear_nxt.isum + inc; // RQ9 RQ18
            timing_nxt = 1'b1;
            opt_nxt = 16'h0;
        end else if (timing_r) begin
            if (open_c) begin
                timing_nxt = 1'b0;
                last_nxt = opt_r; // RQ9
            end else if (ms_tick_r && opt_r != 16'hffff)
                opt_nxt = opt_r + 16'h1;
        end
        wear_nxt.maint_alarm = wear_nxt.op_count >= ops_limit; // RQ13
        if (opt_nxt > optime_limit_ms)
            wear_nxt.slow_alarm = 1'b1; // RQ14
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wear <= '0;
            opt_r <= 16'h0;
            last_optime_ms <= 16'h0;
            timing_r <= 1'b0;
        end else begin
            wear <= wear_nxt;
            opt_r <= opt_nxt;
            last_optime_ms <= last_nxt;
            timing_r <= timing_nxt;
        end
    end

    // Relay routing; bit 6 of 7/8-position masks is F, bit 7 is T
    logic [NUM_RELAYS-1:0] rel_nxt;
    logic run_c, lock_c, blk_c;
    always_comb begin
        run_c = st_r != BRW_IDLE && st_r != BRW_LOCKED;
        lock_c = st_r == BRW_LOCKED;
        blk_c = !ar_enable || ar_block || ops_lock;
        rel_nxt = ({6{trip_nxt}} & map.trip_mask) // RQ4
            | ({6{close_nxt}} & map.close_mask) // RQ5
            | ({6{run_c}} & map.run_mask) // RQ7
            | ({6{ftrip_nxt}} & map.ftrip_mask[5:0]) // RQ6
            | ({6{lock_c}} & map.lock_mask[5:0]) // RQ7
            | ({6{blk_c}} & map.block_mask[5:0]) // RQ7
            | ({6{succ_nxt}} & map.succ_mask[5:0]); // RQ7
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            relay_out <= MASK6_RST;
            ftrip_flag_t <= 1'b0;
            ftrip_flag_f <= 1'b0;
            flag_f <= 1'b0;
            ar_running <= 1'b0;
            breaker_closed_indication <= 1'b0;
            breaker_opened_indication <= 1'b0;
            trip_led <= 1'b0;
            breaker_close_command <= 1'b0;
            trip_pulse <= 1'b0;
        end else begin
            relay_out <= rel_nxt;
            ftrip_flag_t <= ftrip_nxt && map.ftrip_mask[7]; // RQ6
            ftrip_flag_f <= ftrip_nxt && map.ftrip_mask[6]; // RQ6
            flag_f <= (lock_c && map.lock_mask[6])
                || (blk_c && map.block_mask[6])
                || (succ_nxt && map.succ_mask[6]); // RQ7
            ar_running <= run_c;
            breaker_closed_indication <= closed_c; // RQ8
            breaker_opened_indication <= open_c; // RQ8
            trip_led <= led_nxt;
            breaker_close_command <= close_nxt;
            trip_pulse <= trip_nxt;
        end
    end

    a_trip_start: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == BRW_IDLE && st_nxt == BRW_DEAD) |-> trip_r) // RQ1
        else $error("reclose started without trip");
    a_led_on_start: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == BRW_IDLE && st_nxt == BRW_DEAD) |=> trip_led) // RQ2
        else $error("trip led not lit at start");
    a_shot_limit: assert property (@(posedge sys_clk) disable iff (rst)
        shot_r <= 3'(MAX_SHOTS)) // RQ3
        else $error("shot count above limit");
    a_trip_route: assert property (@(posedge sys_clk) disable iff (rst)
        trip_pulse |-> ((relay_out & map.trip_mask) == $past(map.trip_mask)
        || $changed(map.trip_mask))) // RQ4
        else $error("trip not routed");
    a_close_route: assert property (@(posedge sys_clk) disable iff (rst)
        breaker_close_command && $stable(map.close_mask)
        |-> (relay_out & map.close_mask) == map.close_mask) // RQ5
        else $error("close not routed");
    a_lock_noclose: assert property (@(posedge sys_clk) disable iff (rst)
        st_r == BRW_LOCKED ##1 st_r == BRW_LOCKED
        |-> !breaker_close_command) // RQ17
        else $error("close issued while locked");
    a_closed_ind: assert property (@(posedge sys_clk) disable iff (rst)
        contact_mode == 2'h1 |=> breaker_closed_indication
        == $past(breaker_no_contact_input)) // RQ8
        else $error("closed indication wrong");
    a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
        !wear_reset && !open_evt |=> $stable(wear.op_count)) // RQ18
        else $error("count changed without event");
    a_count_inc: assert property (@(posedge sys_clk) disable iff (rst)
        open_evt && !wear_reset |=> wear.op_count
        == $past(wear.op_count) + 16'h1) // RQ10
        else $error("count not incremented");
    c_reclose: cover property (@(posedge sys_clk) disable iff (rst)
        st_r == BRW_CLOSE ##[1:1000] st_r == BRW_RECLAIM);
    c_success: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(succ_r));
    c_final_trip: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(ftrip_r));
endmodule
`default_nettype wire

// >>> brw_breaker_model.sv
/*
 Breaker model: trip and close coils move one main contact, reported by
 two complementary auxiliary contacts after a settable operating delay.
 Assumes coil commands are levels sampled on the relay clock.
*/
`timescale 1ns/10ps
`default_nettype none
module brw_breaker_model (
    input wire logic sys_clk,
    input wire logic trip_coil,
    input wire logic close_coil,
    input wire logic [15:0] op_dly,
    output logic no_contact,
    output logic nc_contact
);
    logic closed_r = 1'b1;
    logic tgt_r = 1'b1;
    int cnt = 0;
    // Mechanism travels only once the coil has dropped
    always @(posedge sys_clk) begin
        if (trip_coil) begin
            tgt_r <= 1'b0;
        end else if (close_coil) begin
            tgt_r <= 1'b1;
        end
        cnt <= (trip_coil || close_coil) ? 0 : cnt + 1;
        if (cnt >= int'(op_dly)) begin
            closed_r <= tgt_r;
        end
    end
    assign no_contact = closed_r;
    assign nc_contact = !closed_r;
endmodule
`default_nettype wire

// >>> testbench.sv
/*
 Self-checking bench for the reclose and wear monitor with a breaker model.
 Assumes MS_CYCLES of 4 so one millisecond is four clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import brw_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    brw_map_s map;
    logic [23:0] shot_sel;
    logic [5:0] element_trip, relay_out;
    logic ar_enable, ar_block, clear_on_close, lockout_reset, ops_lock_en;
    logic [15:0] dead_ms, reclaim_ms, pulse_ms, inh_ms, fault_current;
    logic [15:0] ops_limit, optime_ms, op_dly, last_optime;
    logic manual_close, manual_open, ext_trip, wear_reset, no_c, nc_c;
    logic [1:0] contact_mode;
    brw_law_e sum_law;
    logic trip_led, ftrip_t, ftrip_f, flag_f, ar_running, closed_ind;
    logic opened_ind, close_cmd, trip_pulse;
    brw_wear_s wear;
    int error_cnt = 0;
    int checks = 0;
    int e;
    logic [15:0] exp_ops = 16'h0;
    logic [31:0] exp_isum = 32'h0;

    brw_monitor #(.MS_CYCLES(4)) u_dut (.sys_clk(sys_clk), .rst(rst),
        .map(map), .shot_sel(shot_sel), .element_trip(element_trip),
        .ar_enable(ar_enable), .ar_block(ar_block),
        .clear_on_close(clear_on_close), .lockout_reset(lockout_reset),
        .dead_ms(dead_ms), .reclaim_ms(reclaim_ms), .pulse_ms(pulse_ms),
        .reclose_inhibit_after_close(inh_ms), .manual_close(manual_close),
        .manual_open_command(manual_open), .ext_trip_trigger(ext_trip),
        .contact_mode(contact_mode), .breaker_no_contact_input(no_c),
        .breaker_nc_contact_input(nc_c), .fault_current(fault_current),
        .sum_law(sum_law), .ops_limit(ops_limit),
        .ops_lockout_en(ops_lock_en), .optime_limit_ms(optime_ms),
        .wear_reset(wear_reset), .relay_out(relay_out),
        .trip_led(trip_led), .ftrip_flag_t(ftrip_t), .ftrip_flag_f(ftrip_f),
        .flag_f(flag_f), .ar_running(ar_running),
        .breaker_closed_indication(closed_ind),
        .breaker_opened_indication(opened_ind),
        .breaker_close_command(close_cmd), .trip_pulse(trip_pulse),
        .wear(wear), .last_optime_ms(last_optime));

    brw_breaker_model u_cb (.sys_clk(sys_clk),
        .trip_coil(trip_pulse || manual_open), .close_coil(close_cmd),
        .op_dly(op_dly), .no_contact(no_c), .nc_contact(nc_c));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wait_hi(ref logic sig, input int lim);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        if (sig !== 1'b1) begin
            error_cnt++;
            $display("ERROR t=%0t wait got=%h exp=%h", $time, sig, 1'b1);
            end_of_test();
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask

    // Expected wear after one counted opening
    task automatic count_open;
        exp_ops = exp_ops + 16'h1;
        exp_isum = exp_isum + ((sum_law == BRW_LAW_SQUARE) ?
            32'(fault_current) * 32'(fault_current) : 32'(fault_current));
    endtask

    task automatic do_trip(input logic [5:0] el);
        element_trip = el;
        wait_hi(trip_pulse, 4);
        chk(32'(relay_out), 32'(map.trip_mask));
        element_trip = 6'h00;
        count_open();
    endtask

    task automatic no_close(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(negedge sys_clk);
            hits += int'(close_cmd === 1'b1);
        end
        chk(32'(hits), 32'h0);
    endtask

    task automatic close_by_hand;
        pulse(manual_close);
        wait_hi(close_cmd, 4);
        chk(32'(relay_out), 32'(map.close_mask));
        repeat (30) @(negedge sys_clk);
    endtask

    task automatic chk_wear;
        chk(32'(wear.op_count), 32'(exp_ops));
        chk(wear.isum, exp_isum);
    endtask

    initial begin
        map = '0;
        map.ftrip_mask = 8'h80;
        map.succ_mask = 7'h40;
        {shot_sel, element_trip, ar_block, lockout_reset, inh_ms} = '0;
        {manual_close, manual_open, ext_trip, wear_reset, ops_lock_en} = '0;
        {ar_enable, clear_on_close, contact_mode} = 4'hf;
        {dead_ms, reclaim_ms, pulse_ms} = {16'h5, 16'h14, 16'h2};
        {ops_limit, optime_ms, op_dly} = {16'hffff, 16'h64, 16'h2};
        sum_law = BRW_LAW_SQUARE;
        fault_current = 16'h0;
        void'($urandom(82));
        map.trip_mask = 6'($urandom) | 6'h01;
        map.close_mask = 6'($urandom) | 6'h20;
        fault_current = 16'($urandom) & 16'h0fff;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        chk(32'(relay_out), 32'h0);
        chk_wear();
        repeat (3) @(negedge sys_clk);
        chk(32'({closed_ind, opened_ind}), 32'h2);
        // Full reclose on a random element, all shots enabled
        shot_sel = 24'hffffff;
        e = $urandom_range(5, 0);
        do_trip(6'h01 << e);
        repeat (2) @(negedge sys_clk);
        chk(32'({ar_running, trip_led}), 32'h3);
        wait_hi(close_cmd, 200);
        chk(32'(relay_out), 32'(map.close_mask));
        chk(32'(opened_ind), 32'h1);
        chk_wear();
        chk(32'(last_optime < optime_ms), 32'h1);
        repeat (120) @(negedge sys_clk);
        chk(32'({ar_running, trip_led, closed_ind}), 32'h1);
        chk(32'(flag_f), 32'h1);
        // Second trip after a single selected shot locks out
        shot_sel = 24'(4'h1) << (e * 4);
        do_trip(6'h01 << e);
        wait_hi(close_cmd, 200);
        repeat (20) @(negedge sys_clk);
        do_trip(6'h01 << e);
        no_close(100);
        chk(32'({ftrip_t, ftrip_f}), 32'h2);
        pulse(manual_close);
        no_close(20);
        chk(32'(opened_ind), 32'h1);
        pulse(lockout_reset);
        close_by_hand();
        // Trip right after a manual close is not reclosed
        inh_ms = 16'h32;
        shot_sel = 24'hffffff;
        pulse(manual_close);
        repeat (30) @(negedge sys_clk);
        do_trip(6'h08);
        no_close(80);
        inh_ms = 16'h0;
        repeat (150) @(negedge sys_clk);
        close_by_hand();
        // Manual opens under both summation laws
        for (int k = 0; k < 2; k++) begin
            sum_law = k ? BRW_LAW_SQUARE : BRW_LAW_LINEAR;
            fault_current = 16'($urandom) & 16'h0fff;
            pulse(manual_open);
            count_open();
            repeat (3) @(negedge sys_clk);
            chk_wear();
            close_by_hand();
        end
        pulse(ext_trip);
        count_open();
        repeat (3) @(negedge sys_clk);
        chk_wear();
        chk(32'(wear.slow_alarm), 32'h0);
        // Operations limit raises alarm and blocks reclosing
        ops_limit = exp_ops;
        ops_lock_en = 1'b1;
        @(negedge sys_clk);
        chk(32'(wear.maint_alarm), 32'h1);
        do_trip(6'h02);
        no_close(100);
        ops_lock_en = 1'b0;
        ops_limit = 16'hffff;
        pulse(lockout_reset);
        close_by_hand();
        // Slow breaker beyond the operating time limit
        op_dly = 16'd500;
        pulse(manual_open);
        count_open();
        repeat (540) @(negedge sys_clk);
        chk(32'(wear.slow_alarm), 32'h1);
        chk(32'(last_optime > optime_ms), 32'h1);
        chk_wear();
        // One-contact modes with the breaker open
        contact_mode = 2'h1;
        @(negedge sys_clk);
        chk(32'({closed_ind, opened_ind}), 32'h1);
        contact_mode = 2'h2;
        @(negedge sys_clk);
        chk(32'({closed_ind, opened_ind}), 32'h1);
        contact_mode = 2'h3;
        pulse(wear_reset);
        @(negedge sys_clk);
        chk(32'(wear.op_count) | wear.isum, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
